/* bench/sar_adc_control_sva.sv */
// Concurrent checks on the converter control top ports
// Assumes binding to sar_adc_control, one clock domain
`timescale 1ns/100ps
`include "sar_adc_control_regs.svh"
module sar_adc_control_sva (
    input wire logic                   clock,
    input wire logic                   rst_n,
    input wire sar_adc_pkg::apb_addr_t paddr,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire sar_adc_pkg::apb_data_t pwdata,
    input wire logic [3:0]             pstrb,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   irq,
    input wire logic [2:0]             channel_select,
    input wire logic [7:0]             pin_function,
    input wire logic                   sample_hold
);
    import sar_adc_pkg::*;
    localparam apb_addr_t A_MODE = {`ADC_IDX_MODE, 2'b00};
    localparam apb_addr_t A_GO   = {`ADC_IDX_GO, 2'b00};
    localparam apb_addr_t A_PIN  = {`ADC_IDX_PINFUNC, 2'b00};
    localparam apb_addr_t A_STAT = {`ADC_IDX_IRQ_STATUS, 2'b00};
    logic       acc;
    logic [2:0] wchan;
    logic [7:0] wbyte;
    assign acc = psel && penable && pready;
    assign wchan = pwdata[2:0];
    assign wbyte = pwdata[7:0];
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_reply;
        pready ##1 !pready;
    endsequence
    sequence s_wr(apb_addr_t a);
        acc && pwrite && pstrb[0] && paddr == a;
    endsequence
    property p_reply;
        psel && !penable |=> s_reply;
    endproperty
    property p_mode_rsvd;
        acc && !pwrite && paddr == A_MODE |-> prdata[6:3] == 4'hf;
    endproperty
    property p_go_rsvd;
        acc && !pwrite && paddr == A_GO |-> prdata[6:0] == 7'h7f;
    endproperty
    property p_width;
        acc && !pwrite |-> prdata[31:8] == 24'h0;
    endproperty
    property p_chan;
        s_wr(A_MODE) |=> channel_select == $past(wchan);
    endproperty
    property p_pin;
        s_wr(A_PIN) |=> pin_function == $past(wbyte);
    endproperty
    property p_chan_hold;
        !(acc && pwrite && paddr == A_MODE) |=> $stable(channel_select);
    endproperty
    property p_irq_clr;
        s_wr(A_STAT) ##0 pwdata[0] |=> ##1 !irq;
    endproperty
    property p_sample;
        $rose(sample_hold) |-> sample_hold [*8];
    endproperty
    a_reply: assert property (p_reply)
        else $error("ready pulse malformed");
    a_mode_rsvd: assert property (p_mode_rsvd)
        else $error("mode reserved bits not one");
    a_go_rsvd: assert property (p_go_rsvd)
        else $error("go reserved bits not one");
    a_width: assert property (p_width)
        else $error("read data upper bits set");
    a_chan: assert property (p_chan)
        else $error("channel select not written");
    a_pin: assert property (p_pin)
        else $error("pin function not written");
    a_chan_hold: assert property (p_chan_hold)
        else $error("channel select changed unasked");
    a_irq_clr: assert property (p_irq_clr)
        else $error("interrupt still high after clear");
    a_sample: assert property (p_sample)
        else $error("sample phase too short");
endmodule
bind sar_adc_control sar_adc_control_sva u_sva (.clock, .rst_n, .paddr,
    .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .irq,
    .channel_select, .pin_function, .sample_hold);

/* bench/sar_adc_control_tb_top.sv */
// Self-checking bench for the converter control over APB
// Assumes the analog model answers the comparator input
`timescale 1ns/100ps
`include "sar_adc_control_regs.svh"
module sar_adc_control_tb_top;
    import sar_adc_pkg::*;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    apb_addr_t   paddr = '0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    apb_data_t   pwdata = '0;
    logic [3:0]  pstrb = 4'hf;
    logic [63:0] levels = 64'h0000_ff00_0000_0000;
    apb_data_t   prdata;
    apb_data_t   rd;
    logic        pready, pslverr, irq, sample_hold, compare_high, err;
    logic [2:0]  channel_select;
    logic [7:0]  pin_function, dac_code;
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          cycles = 0;

    always #25 clock = ~clock;

    sar_adc_control dut (.clock(clock), .rst_n(rst_n), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .channel_select(channel_select),
        .pin_function(pin_function), .sample_hold(sample_hold),
        .dac_code(dac_code), .compare_high(compare_high));
    sar_analog_model pins (.levels(levels), .channel_select(channel_select),
        .dac_code(dac_code), .compare_high(compare_high));

    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic wr, input logic [15:0] idx,
                        input apb_data_t d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [15:0] idx, input apb_data_t exp);
        xfer(1'b0, idx, '0);
        check(rd, exp);
    endtask

    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
    endtask

    initial begin
        int k;
        do_reset();
        rchk(`ADC_IDX_MODE, 32'h78);
        rchk(`ADC_IDX_GO, 32'h7f);
        rchk(`ADC_IDX_IRQ_STATUS, 32'h0);
        xfer(1'b1, `ADC_IDX_MODE, 32'h0);
        rchk(`ADC_IDX_MODE, 32'h78);
        xfer(1'b1, `ADC_IDX_PINFUNC, 32'h24);
        @(posedge clock);
        check({24'h0, pin_function}, 32'h24);
        pstrb <= 4'h0;
        xfer(1'b1, `ADC_IDX_PINFUNC, 32'h11);
        pstrb <= 4'hf;
        @(posedge clock);
        check({24'h0, pin_function}, 32'h24);
        xfer(1'b0, 16'h0100, '0);
        check({31'h0, err}, 32'h1);
        xfer(1'b1, `ADC_IDX_IRQ_MASK, 32'h1);
        // Slow on a low pin, then fast on the high pin
        for (int i = 0; i < 2; i++) begin
            xfer(1'b1, `ADC_IDX_MODE, i ? 32'h85 : 32'h02);
            @(posedge clock);
            check({29'h0, channel_select}, i ? 32'h5 : 32'h2);
            rchk(`ADC_IDX_MODE, i ? 32'hfd : 32'h7a);
            xfer(1'b1, `ADC_IDX_GO, 32'h80);
            k = 0;
            do begin
                @(posedge clock);
                k++;
            end while (irq !== 1'b1 && k < 200);
            check(k, i ? 32 : 63);
            rchk(`ADC_IDX_GO, 32'h7f);
            xfer(1'b0, `ADC_IDX_RESULT, '0);
            check({31'h0, rd[7:0] <= (i ? 8'hff : 8'h80)}, 32'h1);
            check({24'h0, rd[7:0]}, i ? 32'hff : 32'h00);
            check({24'h0, dac_code}, i ? 32'hff : 32'h00);
            rchk(`ADC_IDX_IRQ_STATUS, 32'h1);
            xfer(1'b1, `ADC_IDX_IRQ_STATUS, 32'h1);
            repeat (2) @(posedge clock);
            check({31'h0, irq}, 32'h0);
        end
        // Masked completion, then unmask
        xfer(1'b1, `ADC_IDX_IRQ_MASK, 32'h0);
        xfer(1'b1, `ADC_IDX_GO, 32'h80);
        repeat (40) @(posedge clock);
        check({31'h0, irq}, 32'h0);
        rchk(`ADC_IDX_IRQ_STATUS, 32'h1);
        xfer(1'b1, `ADC_IDX_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clock);
        check({31'h0, irq}, 32'h1);
        xfer(1'b1, `ADC_IDX_IRQ_STATUS, 32'h1);
        rchk(`ADC_IDX_RESULT, 32'hff);
        // Stop in mid-conversion
        xfer(1'b1, `ADC_IDX_GO, 32'h80);
        rchk(`ADC_IDX_GO, 32'hff);
        xfer(1'b0, `ADC_IDX_RESULT, '0);
        xfer(1'b1, `ADC_IDX_GO, 32'h0);
        rchk(`ADC_IDX_GO, 32'h7f);
        repeat (40) @(posedge clock);
        rchk(`ADC_IDX_IRQ_STATUS, 32'h0);
        rchk(`ADC_IDX_RESULT, 32'hff);
        do_reset();
        rchk(`ADC_IDX_RESULT, 32'hff);
        rchk(`ADC_IDX_MODE, 32'h78);
        finish_test();
    end
endmodule

/* bench/sar_analog_model.sv */
// Analog input pins seen through the channel multiplexer
// Assumes the bench gives one 8-bit level per pin in levels
`timescale 1ns/100ps
module sar_analog_model (
    input  wire logic [63:0] levels,
    input  wire logic [2:0]  channel_select,
    input  wire logic [7:0]  dac_code,
    output logic             compare_high
);
    // Only the selected pin reaches the comparator
    always_comb begin
        compare_high = levels[{channel_select, 3'b000} +: 8] >= dac_code;
    end
endmodule

/* hw/sar_adc_control.sv */
// APB register front end and top of the 8-bit SAR converter control
// Assumes an external analog mux, DAC and comparator driven from the pins
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`include "sar_adc_control_regs.svh"
module sar_adc_control (
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    input  wire sar_adc_pkg::apb_addr_t paddr,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire sar_adc_pkg::apb_data_t pwdata,
    input  wire logic [3:0]            pstrb,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic                       irq,
    output logic [2:0]                 channel_select,
    output logic [7:0]                 pin_function,
    output logic                       sample_hold,
    output logic [7:0]                 dac_code,
    input  wire logic                  compare_high
);
    import sar_adc_pkg::*;

    sar_ctrl_if ctl ();

    byte_t     mode_reg;
    byte_t     result_reg;
    byte_t     pinfunc_reg;
    byte_t     irq_status_reg;
    byte_t     irq_status_next;
    byte_t     irq_mask_reg;
    apb_data_t prdata_reg;
    logic      pready_reg;
    logic      pslverr_reg;
    logic      irq_reg;
    logic      setup_phase;
    logic      access_done;
    logic      wr_done;
    logic      lane0;
    logic      start_pulse;
    logic      abort_pulse;

    function automatic apb_addr_t byte_addr(input logic [15:0] idx);
        byte_addr = {idx, 2'b00};
    endfunction

    function automatic logic mapped(input apb_addr_t a);
        if (a == byte_addr(`ADC_IDX_MODE))
            mapped = 1'b1;
        else if (a == byte_addr(`ADC_IDX_RESULT))
            mapped = 1'b1;
        else if (a == byte_addr(`ADC_IDX_GO))
            mapped = 1'b1;
        else if (a == byte_addr(`ADC_IDX_PINFUNC))
            mapped = 1'b1;
        else if (a == byte_addr(`ADC_IDX_IRQ_STATUS))
            mapped = 1'b1;
        else if (a == byte_addr(`ADC_IDX_IRQ_MASK))
            mapped = 1'b1;
        else
            mapped = 1'b0;
    endfunction

    sar_timer timer_u (
        .clock (clock),
        .rst_n (rst_n),
        .ctl   (ctl)
    );

    sar_engine engine_u (
        .clock        (clock),
        .rst_n        (rst_n),
        .compare_high (compare_high),
        .ctl          (ctl)
    );

    assign setup_phase = psel && !penable && !pready_reg;
    assign access_done = psel && penable && pready_reg;
    assign lane0       = pstrb[0];
    assign wr_done     = access_done && pwrite && lane0 && !pslverr_reg;

    // Start on a one to the go flag while idle; a zero while busy stops it
    assign start_pulse = wr_done && paddr == byte_addr(`ADC_IDX_GO)
                         && pwdata[`ADC_GO_BIT] && !ctl.busy;
    assign abort_pulse = wr_done && paddr == byte_addr(`ADC_IDX_GO)
                         && !pwdata[`ADC_GO_BIT] && ctl.busy;

    assign ctl.start = start_pulse;
    assign ctl.abort = abort_pulse;
    assign ctl.fast  = mode_reg[`ADC_SPEED_BIT];

    assign prdata         = prdata_reg;
    assign pready         = pready_reg;
    assign pslverr        = pslverr_reg;
    assign irq            = irq_reg;
    assign channel_select = mode_reg[`ADC_CHAN_MSB:`ADC_CHAN_LSB];
    assign pin_function   = pinfunc_reg;
    assign sample_hold    = ctl.sampling;
    assign dac_code       = ctl.code;

    // APB handshake: no wait states, answer prepared in the setup cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (setup_phase) begin
            pready_reg  <= 1'b1;
            pslverr_reg <= !mapped(paddr);
        end else begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    // Read data; reserved bits read as one, write-only reads as zero
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prdata_reg <= `ADC_WORD_ZERO;
        end else if (setup_phase && !pwrite) begin
            if (paddr == byte_addr(`ADC_IDX_MODE))
                prdata_reg <= {24'h000000,
                               mode_reg | `ADC_MODE_RSVD_MASK};
            else if (paddr == byte_addr(`ADC_IDX_RESULT))
                prdata_reg <= {24'h000000, result_reg};
            else if (paddr == byte_addr(`ADC_IDX_GO))
                prdata_reg <= {24'h000000, ctl.busy,
                               7'(`ADC_GO_RSVD_MASK)};
            else if (paddr == byte_addr(`ADC_IDX_IRQ_STATUS))
                prdata_reg <= {24'h000000, irq_status_reg};
            else if (paddr == byte_addr(`ADC_IDX_IRQ_MASK))
                prdata_reg <= {24'h000000, irq_mask_reg};
            else
                prdata_reg <= `ADC_WORD_ZERO;
        end else if (access_done) begin
            prdata_reg <= `ADC_WORD_ZERO;
        end
    end

    // Mode register: only speed and channel bits are stored
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mode_reg <= `ADC_MODE_RESET;
        end else if (wr_done && paddr == byte_addr(`ADC_IDX_MODE)) begin
            mode_reg <= (pwdata[7:0] & ~`ADC_MODE_RSVD_MASK)
                        | `ADC_MODE_RSVD_MASK;
        end
    end

    // Pin function register drives the analog pin enables
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pinfunc_reg <= `ADC_PINFUNC_RESET;
        end else if (wr_done && paddr == byte_addr(`ADC_IDX_PINFUNC)) begin
            pinfunc_reg <= pwdata[7:0];
        end
    end

    // Result latched with the flag clear; no reset on purpose
    always_ff @(posedge clock) begin
        if (ctl.done) begin
            result_reg <= ctl.code;
        end
    end

    // Sticky completion status, write one to clear, set wins
    always_comb begin
        irq_status_next = irq_status_reg;
        if (wr_done && paddr == byte_addr(`ADC_IDX_IRQ_STATUS)) begin
            irq_status_next = irq_status_reg & ~pwdata[7:0];
        end
        if (ctl.done) begin
            irq_status_next[`ADC_IRQ_DONE_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_status_reg <= `ADC_IRQ_RESET;
        end else begin
            irq_status_reg <= irq_status_next;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_mask_reg <= `ADC_IRQ_RESET;
        end else if (wr_done && paddr == byte_addr(`ADC_IDX_IRQ_MASK)) begin
            irq_mask_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_status_next & irq_mask_reg);
        end
    end
endmodule

/* hw/sar_adc_control_regs.svh */
// Register indices, field positions, reset values and period counts
// Assumes inclusion by every module of the converter control block
`ifndef SAR_ADC_CONTROL_REGS_SVH
`define SAR_ADC_CONTROL_REGS_SVH

`define ADC_IDX_MODE        16'hffbc
`define ADC_IDX_RESULT      16'hffbd
`define ADC_IDX_GO          16'hffbe
`define ADC_IDX_PINFUNC     16'hffef
`define ADC_IDX_IRQ_STATUS  16'hffc0
`define ADC_IDX_IRQ_MASK    16'hffc1

`define ADC_MODE_RESET      8'h78
`define ADC_MODE_RSVD_MASK  8'h78
`define ADC_GO_RESET        8'h7f
`define ADC_GO_RSVD_MASK    8'h7f
`define ADC_PINFUNC_RESET   8'h00
`define ADC_IRQ_RESET       8'h00

`define ADC_SPEED_BIT       7
`define ADC_GO_BIT          7
`define ADC_CHAN_MSB        2
`define ADC_CHAN_LSB        0
`define ADC_IRQ_DONE_BIT    0

`define ADC_PERIOD_SLOW     6'd62
`define ADC_PERIOD_FAST     6'd31
`define ADC_TRIAL_COUNT     6'd8
`define ADC_COUNT_ZERO      6'd0
`define ADC_COUNT_ONE       6'd1
`define ADC_COUNT_TWO       6'd2
`define ADC_CODE_MID        8'h80
`define ADC_CODE_ZERO       8'h00
`define ADC_WORD_ZERO       32'h0000_0000

`endif

/* hw/sar_adc_pkg.sv */
// Types shared by the converter control modules
// Assumes the register header is available on the include path
package sar_adc_pkg;
    typedef logic [7:0]  byte_t;
    typedef logic [5:0]  count_t;
    typedef logic [17:0] apb_addr_t;
    typedef logic [31:0] apb_data_t;
    typedef enum {conv_idle, conv_run} conv_state_t;
endpackage

/* hw/sar_ctrl_if.sv */
// Signals between the register front end, the timer and the engine
// Assumes one clock domain shared by all three modules
`timescale 1ns/100ps
interface sar_ctrl_if;
    import sar_adc_pkg::*;
    logic   start;
    logic   abort;
    logic   fast;
    logic   busy;
    logic   done;
    count_t count;
    byte_t  code;
    logic   sampling;

    modport ctrl   (output start, output abort, output fast,
                    input busy, input done, input code, input sampling);
    modport timer  (input start, input abort, input fast,
                    output busy, output done, output count);
    modport engine (input start, input count, input busy,
                    output code, output sampling);
endinterface

/* hw/sar_engine.sv */
// Successive approximation of one sample against an external comparator
// Assumes compare_high is settled one cycle after dac_code changes
`timescale 1ns/100ps
`include "sar_adc_control_regs.svh"
module sar_engine (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic compare_high,
    sar_ctrl_if.engine ctl
);
    import sar_adc_pkg::*;

    byte_t code_reg;
    logic  sampling_reg;

    assign ctl.code     = code_reg;
    assign ctl.sampling = sampling_reg;

    function automatic byte_t bit_mask(input count_t idx);
        bit_mask = byte_t'(1) << idx[2:0];
    endfunction

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            code_reg     <= `ADC_CODE_ZERO;
            sampling_reg <= 1'b0;
        end else if (ctl.start && !ctl.busy) begin
            code_reg     <= `ADC_CODE_MID;
            sampling_reg <= 1'b1;
        end else if (ctl.busy && ctl.count > `ADC_TRIAL_COUNT) begin
            sampling_reg <= 1'b1;
        end else if (ctl.busy && ctl.count != `ADC_COUNT_ZERO) begin
            sampling_reg <= 1'b0;
            // Keep or drop the trial bit, then try the next lower one
            if (ctl.count == `ADC_COUNT_ONE) begin
                code_reg <= compare_high ? code_reg
                    : code_reg & ~bit_mask(ctl.count - `ADC_COUNT_ONE);
            end else begin
                code_reg <= (compare_high ? code_reg
                    : code_reg & ~bit_mask(ctl.count - `ADC_COUNT_ONE))
                    | bit_mask(ctl.count - `ADC_COUNT_TWO);
            end
        end else begin
            sampling_reg <= 1'b0;
        end
    end
endmodule

/* hw/sar_timer.sv */
// Conversion period counter in system clock periods
// Assumes start and abort are one-cycle pulses from the register front end
`timescale 1ns/100ps
`include "sar_adc_control_regs.svh"
module sar_timer (
    input  wire logic clock,
    input  wire logic rst_n,
    sar_ctrl_if.timer ctl
);
    import sar_adc_pkg::*;

    conv_state_t state_reg;
    count_t      count_reg;

    assign ctl.busy  = (state_reg == conv_run);
    assign ctl.done  = (state_reg == conv_run) && !ctl.abort
                       && count_reg == `ADC_COUNT_ZERO;
    assign ctl.count = count_reg;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= conv_idle;
            count_reg <= `ADC_COUNT_ZERO;
        end else begin
            case (state_reg)
                conv_idle: begin
                    if (ctl.start) begin
                        state_reg <= conv_run;
                        count_reg <= ctl.fast
                            ? `ADC_PERIOD_FAST - `ADC_COUNT_ONE
                            : `ADC_PERIOD_SLOW - `ADC_COUNT_ONE;
                    end
                end
                conv_run: begin
                    if (ctl.abort) begin
                        state_reg <= conv_idle;
                    end else if (count_reg == `ADC_COUNT_ZERO) begin
                        state_reg <= conv_idle;
                    end else begin
                        count_reg <= count_reg - `ADC_COUNT_ONE;
                    end
                end
                default: state_reg <= conv_idle;
            endcase
        end
    end
endmodule
